// ---- design/pin_sync.v ----
`timescale 1ns/1ns
// ==========================================================
// Two-stage synchroniser for a vector of pin inputs
module pin_sync #(
  parameter             WIDTH       = 3,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input  wire             CLK,
  input  wire             RST_N,
  input  wire [WIDTH-1:0] PIN,
  output reg  [WIDTH-1:0] SYNCED
);
  reg [WIDTH-1:0] stage1;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stage1 <= RESET_VALUE;
      SYNCED <= RESET_VALUE;
    end else begin
      stage1 <= PIN;
      SYNCED <= stage1;
    end
  end
endmodule

// ---- design/spi_wiper_register_port.v ----
`timescale 1ns/1ns
// What this block does
// R1 - Capture SDI on SCK rise while selected
// R2 - Launch SDO bits on SCK fall
// R3 - Control bit 1 selects push-pull or open-drain
// R4 - Output type defaults to push-pull
// R5 - SDO released while chip select high
// R6 - Active while selected, standby otherwise
// R7 - Nothing accepted before first select fall
// R8 - Wiper output follows 8-bit position register
// R9 - Serial stream decoded into opcode, address, data
// R10 - Instruction byte MSB first: 3 op, 5 address
// R11 - Address 10000 control, 0 or 1 wiper
// R12 - Writes commit at chip select rising edge
// R13 - Read returns echoed instruction, then value
// R14 - Bit and byte counters cleared when deselected
`include "wiper_port_consts.vh"

module spi_wiper_register_port (
  input  wire       CLK,
  input  wire       RST_N,
  input  wire       SCK,
  input  wire       SDI,
  input  wire       CS_N,
  output wire       SDO_OUT,
  output wire       SDO_OE,
  output wire [7:0] WIPER_TAP,
  output wire       SHUTDOWN_N,
  output wire       ACTIVE
);
  // ==========================================================
  // Pin synchronisation
  wire [2:0] synced;
  wire       sck_s;
  wire       sdi_s;
  wire       cs_n_s;

  // Reset to idle pin levels: SCK low, SDI and CS_N high
  pin_sync #(.WIDTH(3), .RESET_VALUE(3'h3)) u_sync (
    .CLK         (CLK),
    .RST_N       (RST_N),
    .PIN         ({SCK, SDI, CS_N}),
    .SYNCED      (synced)
  );
  assign sck_s  = synced[2];
  assign sdi_s  = synced[1];
  assign cs_n_s = synced[0];

  reg sck_d;
  reg cs_n_d;
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire cs_fall  = ~cs_n_s & cs_n_d;
  wire cs_rise  = cs_n_s & ~cs_n_d;

  // ==========================================================
  // Registers and framing state
  reg [7:0] wiper;
  reg [7:0] access_ctrl;
  reg       armed;
  reg       in_frame;
  reg [2:0] bit_cnt;
  reg [1:0] byte_cnt;
  reg       byte_full;
  reg [7:0] shift_in;
  reg [7:0] instr;
  reg [7:0] wr_data;
  reg       wr_pending;
  reg [7:0] shift_out;
  reg       sdo_bit;

  function [7:0] read_value;
    input [2:0] op;
    input [4:0] addr;
    input [7:0] w;
    input [7:0] a;
    begin
      if (op == `OP_CTRL_READ)
        read_value = a;
      else if (addr == `ADDR_ACCESS_CTRL)
        read_value = a;                                // [R11]
      else if (addr == `ADDR_WIPER0 || addr == `ADDR_WIPER1)
        read_value = w;                                // [R11]
      else
        read_value = 8'h00;
    end
  endfunction

  wire [7:0] next_shift_in = {shift_in[6:0], sdi_s};  // [R10]
  wire [2:0] cur_op        = instr[`INSTR_OP_HI:`INSTR_OP_LO];
  wire [4:0] cur_addr      = instr[`INSTR_ADDR_HI:`INSTR_ADDR_LO];
  wire       is_write      = (cur_op == `OP_REG_WRITE) || (cur_op == `OP_CTRL_WRITE);
  wire       is_read       = (cur_op == `OP_REG_READ) || (cur_op == `OP_CTRL_READ);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_d       <= 1'b0;
      cs_n_d      <= 1'b1;
      wiper       <= `WIPER_RESET;
      access_ctrl <= `ACCESS_CTRL_RESET;               // [R4]
      armed       <= 1'b0;
      in_frame    <= 1'b0;
      bit_cnt     <= 3'h7;
      byte_cnt    <= 2'h0;
      byte_full   <= 1'b0;
      shift_in    <= 8'h00;
      instr       <= 8'h00;
      wr_data     <= 8'h00;
      wr_pending  <= 1'b0;
      shift_out   <= 8'h00;
      sdo_bit     <= 1'b1;
    end else begin
      sck_d  <= sck_s;
      cs_n_d <= cs_n_s;
      if (cs_fall) begin
        armed    <= 1'b1;                              // [R7]
        in_frame <= 1'b1;
      end
      if (cs_n_s) begin
        bit_cnt    <= 3'h7;                            // [R14]
        byte_cnt   <= 2'h0;                            // [R14]
        byte_full  <= 1'b0;
        in_frame   <= 1'b0;
        sdo_bit    <= 1'b1;
        if (cs_rise && wr_pending && in_frame) begin   // [R12]
          wr_pending <= 1'b0;
          if (cur_op == `OP_CTRL_WRITE || cur_addr == `ADDR_ACCESS_CTRL)
            access_ctrl <= wr_data & `ACCESS_CTRL_WRITE_MASK;  // [R3]
          else if (cur_addr == `ADDR_WIPER0 || cur_addr == `ADDR_WIPER1)
            wiper <= wr_data;                          // [R8]
        end else if (cs_rise) begin
          wr_pending <= 1'b0;
        end
      end else if (armed && in_frame) begin            // [R6]
        if (sck_rise) begin
          shift_in <= next_shift_in;                   // [R1]
          bit_cnt  <= bit_cnt - 3'h1;
          if (bit_cnt == 3'h0) begin
            byte_full <= 1'b1;
            if (byte_cnt != 2'h3)
              byte_cnt <= byte_cnt + 2'h1;
            if (byte_cnt == 2'h0)
              instr <= next_shift_in;                  // [R9]
            else if (byte_cnt == 2'h1 && is_write) begin
              wr_data    <= next_shift_in;
              wr_pending <= 1'b1;
            end
            if (byte_cnt == 2'h1 && is_read)
              shift_out <= instr;                      // [R13]
            else if (byte_cnt == 2'h2 && is_read)
              shift_out <= read_value(cur_op, cur_addr, wiper, access_ctrl); // [R13]
          end
        end
        if (sck_fall && byte_full && is_read && byte_cnt >= 2'h2) begin
          sdo_bit   <= shift_out[7];                   // [R2]
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // Output driver
  wire open_drain = access_ctrl[`ACCESS_CTRL_SDO_TYPE_BIT];
  wire selected   = ~cs_n_s & armed & in_frame;

  assign SDO_OUT    = open_drain ? 1'b0 : sdo_bit;           // [R3]
  assign SDO_OE     = selected & (open_drain ? ~sdo_bit : 1'b1); // [R5]
  assign WIPER_TAP  = wiper;                                  // [R8]
  assign SHUTDOWN_N = access_ctrl[`ACCESS_CTRL_SHUTDOWN_N_BIT];
  assign ACTIVE     = ~cs_n_s;                                // [R6]
endmodule

// ---- design/wiper_port_consts.vh ----
`ifndef WIPER_PORT_CONSTS_VH
`define WIPER_PORT_CONSTS_VH

// Register addresses (5-bit address field)
`define ADDR_WIPER0        5'h00
`define ADDR_WIPER1        5'h01
`define ADDR_ACCESS_CTRL   5'h10

// Reset values
`define WIPER_RESET        8'h80
`define ACCESS_CTRL_RESET  8'h40

// Access control register fields
`define ACCESS_CTRL_SDO_TYPE_BIT    1
`define ACCESS_CTRL_SHUTDOWN_N_BIT  6
`define ACCESS_CTRL_WRITE_MASK      8'h42

// Instruction byte fields
`define INSTR_OP_HI        7
`define INSTR_OP_LO        5
`define INSTR_ADDR_HI      4
`define INSTR_ADDR_LO      0

// Operation codes
`define OP_NOP             3'h0
`define OP_CTRL_READ       3'h1
`define OP_CTRL_WRITE      3'h3
`define OP_REG_READ        3'h4
`define OP_REG_WRITE       3'h6

`endif

// ---- verification/spi_host_model.sv ----
`timescale 1ns/1ns
module spi_host_model (
  input  wire CLK,
  input  wire SDO_OUT,
  input  wire SDO_OE,
  output reg  SCK,
  output reg  SDI,
  output reg  CS_N
);
  // Off-chip pull-up on the data line
  wire sdo_line = SDO_OE ? SDO_OUT : 1'b1;
  initial begin
    SCK = 0;
    SDI = 0;
    CS_N = 1;
  end
  task half;
    begin
      repeat (4) @(posedge CLK);
      #1;
    end
  endtask
  task frame(input [31:0] tx, input integer n, output [31:0] rx);
    integer i;
    begin
      rx = 0;
      CS_N = 0;
      half;
      for (i = n - 1; i >= 0; i = i - 1) begin
        SDI = tx[i];
        half;
        SCK = 1;
        rx = {rx[30:0], sdo_line};
        half;
        SCK = 0;
      end
      half;
      CS_N = 1;
      SDI = ~SDI;
      half;
      half;
    end
  endtask
endmodule

// ---- verification/spi_port_assertions.sv ----
`timescale 1ns/1ns
`include "wiper_port_consts.vh"
module spi_port_checker (
  input wire       CLK,
  input wire       RST_N,
  input wire       SCK,
  input wire       CS_N,
  input wire       SDO_OUT,
  input wire       SDO_OE,
  input wire [7:0] WIPER_TAP,
  input wire       SHUTDOWN_N,
  input wire       ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_OE_OFF: assert property (CS_N [*4] |-> !SDO_OE)
    else $error("sdo driven idle");
  AST_STANDBY: assert property (CS_N [*4] |-> !ACTIVE)
    else $error("active idle");
  AST_WAKE: assert property ($fell(CS_N) ##1 !CS_N [*4] |-> ACTIVE)
    else $error("not active");
  AST_OE_SEL: assert property (SDO_OE |-> ACTIVE)
    else $error("oe in standby");
  AST_WIPER_HOLD: assert property (!CS_N [*6] |-> $stable(WIPER_TAP))
    else $error("wiper moved in frame");
  AST_SHDN_HOLD: assert property (!CS_N [*6] |-> $stable(SHUTDOWN_N))
    else $error("shutdown moved in frame");
  AST_SDO_HOLD: assert property ((!CS_N && SCK) [*4] |-> $stable(SDO_OUT))
    else $error("sdo moved with sck high");
  AST_RST_VAL: assert property ($rose(RST_N) |-> WIPER_TAP == `WIPER_RESET && SHUTDOWN_N)
    else $error("bad reset value");
endmodule
bind spi_wiper_register_port spi_port_checker chk_u (.CLK(CLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N),
  .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE), .WIPER_TAP(WIPER_TAP), .SHUTDOWN_N(SHUTDOWN_N), .ACTIVE(ACTIVE));

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
  reg         CLK;
  reg         RST_N;
  wire        SCK, SDI, CS_N, SDO_OUT, SDO_OE, SHUTDOWN_N, ACTIVE;
  wire [7:0]  WIPER_TAP;
  reg  [31:0] rx;
  reg  [15:0] got;
  reg  [15:0] exp_q[$];
  reg  [7:0]  val;
  reg         pp_seen;
  integer     seed, miscompares, comparisons, cycles, k;
  event       ev;
  spi_wiper_register_port dut_u (.CLK(CLK), .RST_N(RST_N), .SCK(SCK), .SDI(SDI), .CS_N(CS_N),
    .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE), .WIPER_TAP(WIPER_TAP), .SHUTDOWN_N(SHUTDOWN_N), .ACTIVE(ACTIVE));
  spi_host_model host_u (.CLK(CLK), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE), .SCK(SCK), .SDI(SDI), .CS_N(CS_N));
  initial begin
    CLK = 0;
    forever #5 CLK = ~CLK;
  end
  task give_verdict;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] e, input [15:0] g);
    begin
      exp_q.push_back(e);
      got = g;
      ->ev;
      #1;
    end
  endtask
  always @(ev) begin
    comparisons = comparisons + 1;
    if (got !== exp_q[0]) begin
      miscompares = miscompares + 1;
      $display("BAD %0t %h %h", $time, got, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  always @(posedge CLK) begin
    cycles = cycles + 1;
    if (SDO_OE && SDO_OUT) pp_seen = 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  initial begin
    seed = 32'he80d;
    {miscompares, comparisons, cycles, pp_seen, RST_N} = 0;
    repeat (4) @(posedge CLK);
    #1 RST_N = 1;
    host_u.half;
    host_u.frame(32'h8000_0000, 32, rx);
    chk(rx[15:0], 16'h8080);
    chk(pp_seen, 16'h0001);
    for (k = 0; k < 2; k = k + 1) begin
      val = $random(seed);
      host_u.frame({8'hC0 | k[7:0], val}, 16, rx);
      chk(WIPER_TAP, val);
      host_u.frame({8'h80 | k[7:0], 24'h0}, 32, rx);
      chk(rx[15:0], {8'h80 | k[7:0], val});
      host_u.frame({8'hC0, ~val} >> 4, 12, rx);
      chk(WIPER_TAP, val);
    end
    host_u.frame(32'h6002, 16, rx);
    chk(SHUTDOWN_N, 16'h0000);
    pp_seen = 0;
    host_u.frame(32'h2000_0000, 32, rx);
    chk(rx[15:0], 16'h2002);
    chk(pp_seen, 16'h0000);
    host_u.frame(32'hD040, 16, rx);
    host_u.frame(32'h9000_0000, 32, rx);
    chk(rx[15:0], 16'h9040);
    give_verdict;
  end
endmodule
